// ==== hdl/rvt_ring_validate.sv ====
// ring validation timer with an ahb-lite register slave
//
// Notes on behaviour
// - delay select 0..7 delays valid-ring indication by select times 256 ms
// - delay select msb is ctrl2 bit 7, low bits are ctrl1 bits 7:6
// - each ring event during qualification reloads timer from assertion time
// - event with timer above maximum count means too fast: ring invalid
// - assertion minus maximum count sets shortest event gap, 2 ms units
// - six-bit maximum count sets the highest accepted ring frequency
// - ring ends when timeout (n x 128 ms) passes since last crossing
// - ring valid only after frequency held in tolerance for confirm time
// - event after the assertion timer expired means too slow: ring invalid
// - validation runs only while enable bit is set, in any power mode
`default_nettype none

module rvt_ring_validate #(
   parameter int unsigned TICK_CYCLES = rvt_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // line side
   input  wire logic        ringEvent,
   // results
   output logic             ringValid,
   output logic             irq
);
   import rvt_pkg::*;

   // ---------------------------------------------------------
   // tick
   // ---------------------------------------------------------
   rvt_tick_if tkIf ();

   rvt_tick_gen #(.CYCLES(TICK_CYCLES)) uTick (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tk      (tkIf.gen)
   );

   // ---------------------------------------------------------
   // register fields
   // ---------------------------------------------------------
   logic [7:0]      ctrl1_q, ctrl1_d;
   logic [7:0]      ctrl2_q, ctrl2_d;
   logic [7:0]      ctrl3_q, ctrl3_d;
   logic [ST_W-1:0] status_q, status_d;
   logic [ST_W-1:0] mask_q, mask_d;
   logic [ST_W-1:0] evSet;

   logic       enable;
   logic [2:0] dlySel;
   logic [5:0] maxCnt;
   logic [5:0] assertTime;
   logic [3:0] toutSel;
   logic [2:0] confSel;
   logic [9:0] confTarget;
   logic [9:0] dlyTarget;
   logic [9:0] toutTarget;

   assign enable     = ctrl3_q[EN_BIT];
   assign dlySel     = {ctrl2_q[DLY_HI_BIT],
                        ctrl1_q[DLY_LO_MSB:DLY_LO_LSB]};
   assign maxCnt     = ctrl1_q[MAX_MSB:0];
   assign assertTime = ctrl3_q[RAS_MSB:0];
   assign toutSel    = ctrl2_q[TOUT_MSB:TOUT_LSB];
   assign confSel    = ctrl2_q[CONF_MSB:0];
   assign confTarget = 10'(CONFIRM_MS[confSel] / TICK_MS);
   assign dlyTarget  = 10'(int'(dlySel) * DELAY_STEP_TK);
   assign toutTarget = 10'(int'(toutSel) * TOUT_STEP_TK);

   // ---------------------------------------------------------
   // ring qualification
   // ---------------------------------------------------------
   rvt_state_t state_q, state_d;
   logic [5:0] assertTmr_q, assertTmr_d;
   logic [9:0] confCnt_q, confCnt_d;
   logic [9:0] delayCnt_q, delayCnt_d;
   logic [9:0] sinceEdge_q, sinceEdge_d;
   logic       ringValid_q, ringValid_d;
   logic       tick;
   logic       tooHigh;
   logic       tooLow;

   // timers only tick while the block is enabled
   assign tkIf.run = enable;
   assign tick     = tkIf.tick;
   // remaining time above max count: events too close
   assign tooHigh  = assertTmr_q > maxCnt;
   // timer already run out: events too far apart
   assign tooLow   = assertTmr_q == 6'h00;

   always_comb begin
      state_d     = state_q;
      assertTmr_d = assertTmr_q;
      confCnt_d   = confCnt_q;
      delayCnt_d  = delayCnt_q;
      sinceEdge_d = sinceEdge_q;
      evSet       = '0;
      if (!enable) begin
         state_d     = RVT_IDLE;
         assertTmr_d = '0;
         confCnt_d   = '0;
         delayCnt_d  = '0;
         sinceEdge_d = '0;
      end else begin
         if (tick && state_q != RVT_IDLE) begin
            // count ticks since the last crossing
            sinceEdge_d = sinceEdge_q + 1'b1;
            if (sinceEdge_d >= toutTarget) begin
               state_d   = RVT_IDLE;
               evSet[ST_END] = 1'b1;
            end
         end
         case (state_q)
            RVT_IDLE: begin
               if (ringEvent) begin
                  state_d     = RVT_QUAL;
                  assertTmr_d = assertTime;
                  confCnt_d   = '0;
                  delayCnt_d  = '0;
               end
            end
            RVT_QUAL: begin
               if (ringEvent) begin
                  assertTmr_d = assertTime;
                  evSet[ST_HIGH] = tooHigh;
                  evSet[ST_LOW]  = tooLow;
               end else if (tick && !tooLow) begin
                  assertTmr_d = assertTmr_q - 1'b1;
               end
               // gap shorter than assertion minus max count, or timer already run out
               if (ringEvent && (tooHigh || tooLow)) begin
                  confCnt_d = '0;
               // a tick that meets a good event still counts
               end else if (tick && !tooLow) begin
                  confCnt_d = confCnt_q + 1'b1;
                  if (confCnt_d >= confTarget && state_d == RVT_QUAL) begin
                     if (dlySel == 3'h0) begin
                        state_d = RVT_VALID;
                        evSet[ST_VALID] = 1'b1;
                     end else begin
                        state_d = RVT_DELAY;
                     end
                  end
               end
            end
            RVT_DELAY: begin
               // hold the indication back by the delay
               if (tick && state_d == RVT_DELAY) begin
                  delayCnt_d = delayCnt_q + 1'b1;
                  if (delayCnt_d >= dlyTarget) begin
                     state_d = RVT_VALID;
                     evSet[ST_VALID] = 1'b1;
                  end
               end
            end
            RVT_VALID: begin
            end
            default: begin
               state_d = RVT_IDLE;
            end
         endcase
         if (ringEvent) begin
            sinceEdge_d = '0;
         end
      end
      ringValid_d = state_d == RVT_VALID;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q     <= RVT_IDLE;
         assertTmr_q <= '0;
         confCnt_q   <= '0;
         delayCnt_q  <= '0;
         sinceEdge_q <= '0;
         ringValid_q <= 1'b0;
      end else begin
         state_q     <= state_d;
         assertTmr_q <= assertTmr_d;
         confCnt_q   <= confCnt_d;
         delayCnt_q  <= delayCnt_d;
         sinceEdge_q <= sinceEdge_d;
         ringValid_q <= ringValid_d;
      end
   end

   assign ringValid = ringValid_q;

   // ---------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ---------------------------------------------------------
   logic        wrPend_q, wrPend_d;
   logic [7:0]  wrAddr_q, wrAddr_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic        irq_q, irq_d;
   logic        accept;
   logic        mapped;

   assign accept = hsel && htrans[1] && hready;
   // upper address bits must be zero, else unmapped
   assign mapped = haddr[31:8] == 24'h000000;

   always_comb begin
      ctrl1_d  = ctrl1_q;
      ctrl2_d  = ctrl2_q;
      ctrl3_d  = ctrl3_q;
      mask_d   = mask_q;
      status_d = status_q;
      wrPend_d = accept && hwrite && mapped;
      wrAddr_d = haddr[7:0];
      hrdata_d = '0;
      if (wrPend_q) begin
         case (wrAddr_q)
            CTRL1_ADDR:  ctrl1_d  = hwdata[7:0];
            CTRL2_ADDR:  ctrl2_d  = hwdata[7:0];
            CTRL3_ADDR:  ctrl3_d  = hwdata[7:0] & CTRL3_WMASK;
            MASK_ADDR:   mask_d   = hwdata[ST_W-1:0];
            STATUS_ADDR: status_d = status_q & ~hwdata[ST_W-1:0];
            default: begin
            end
         endcase
      end
      // a new event beats a simultaneous write-one-to-clear
      status_d = status_d | evSet;
      if (accept && !hwrite && mapped) begin
         case (haddr[7:0])
            CTRL1_ADDR:  hrdata_d = {24'h000000, ctrl1_q};
            CTRL2_ADDR:  hrdata_d = {24'h000000, ctrl2_q};
            CTRL3_ADDR:  hrdata_d = {24'h000000, ctrl3_q};
            MASK_ADDR:   hrdata_d = {28'h0000000, mask_q};
            STATUS_ADDR: hrdata_d = {28'h0000000, status_q};
            STATE_ADDR:  hrdata_d = {27'h0000000, state_q, ringValid_q};
            default:     hrdata_d = '0;
         endcase
      end
      irq_d = |(status_d & mask_d);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl1_q  <= CTRL1_RST;
         ctrl2_q  <= CTRL2_RST;
         ctrl3_q  <= CTRL3_RST;
         mask_q   <= '0;
         status_q <= '0;
         wrPend_q <= 1'b0;
         wrAddr_q <= '0;
         hrdata_q <= '0;
         irq_q    <= 1'b0;
      end else begin
         ctrl1_q  <= ctrl1_d;
         ctrl2_q  <= ctrl2_d;
         ctrl3_q  <= ctrl3_d;
         mask_q   <= mask_d;
         status_q <= status_d;
         wrPend_q <= wrPend_d;
         wrAddr_q <= wrAddr_d;
         hrdata_q <= hrdata_d;
         irq_q    <= irq_d;
      end
   end

   assign hrdata    = hrdata_q;
   assign irq       = irq_q;
   assign hresp     = 1'b0;
   assign hreadyout = 1'b1;

   // ---------------------------------------------------------
   // assertions
   // ---------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_event_reload: assert property (
      enable && state_q == RVT_QUAL && ringEvent |=>
         assertTmr_q == $past(assertTime))
      else $error("assertion timer not reloaded on event");

   a_tick_decrement: assert property (
      enable && state_q == RVT_QUAL && !ringEvent && tick && !tooLow
      && !(sinceEdge_q + 10'h001 >= toutTarget) |=>
         assertTmr_q == $past(assertTmr_q) - 6'h01)
      else $error("assertion timer did not step on tick");

   a_too_high: assert property (
      enable && state_q == RVT_QUAL && ringEvent && tooHigh |=>
         status_q[ST_HIGH] && confCnt_q == 10'h000)
      else $error("fast ring not invalidated");

   a_too_low: assert property (
      enable && state_q == RVT_QUAL && ringEvent && tooLow |=>
         status_q[ST_LOW] && confCnt_q == 10'h000)
      else $error("slow ring not invalidated");

   a_disabled_idle: assert property (
      !enable |=> state_q == RVT_IDLE && !ringValid ##1 !tkIf.tick)
      else $error("block active while disabled");

   a_confirm_time: assert property (
      state_q == RVT_QUAL && state_d inside {RVT_DELAY, RVT_VALID}
      |-> confCnt_q + 10'h001 == confTarget)
      else $error("confirm time wrong");

   a_delay_length: assert property (
      state_q == RVT_DELAY && state_d == RVT_VALID
      |-> delayCnt_q + 10'h001 == dlyTarget && dlySel != 3'h0)
      else $error("indication delay wrong");

   a_timeout_end: assert property (
      enable && state_q != RVT_IDLE && tick && !ringEvent
      && sinceEdge_q + 10'h001 >= toutTarget
      |=> state_q == RVT_IDLE && !ringValid && status_q[ST_END])
      else $error("ring not ended on timeout");

   a_irq_level: assert property (
      ##1 irq == |($past(status_d) & $past(mask_d)))
      else $error("interrupt level wrong");

   c_ring_valid: cover property (state_q == RVT_DELAY ##1
      state_q == RVT_VALID);
   c_ring_fast: cover property (state_q == RVT_QUAL && ringEvent
      && tooHigh);
   c_ring_end: cover property (ringValid ##1 !ringValid);

endmodule : rvt_ring_validate

`default_nettype wire

// ==== hdl/rvt_pkg.sv ====
// shared constants and types for the ring validation timer
`default_nettype none

package rvt_pkg;

   // ---------------------------------------------------------
   // timing
   // ---------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned TICK_PERIOD_NS = 2000000;
   localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned TICK_MS        = 2;
   localparam int unsigned DELAY_STEP_MS  = 256;
   localparam int unsigned TOUT_STEP_MS   = 128;
   localparam int unsigned DELAY_STEP_TK  = DELAY_STEP_MS / TICK_MS;
   localparam int unsigned TOUT_STEP_TK   = TOUT_STEP_MS / TICK_MS;
   localparam int unsigned CONFIRM_MS [8] =
      '{100, 150, 200, 256, 384, 512, 640, 1024};

   // ---------------------------------------------------------
   // register map
   // ---------------------------------------------------------
   localparam logic [7:0] CTRL1_IDX   = 8'h16;
   localparam logic [7:0] CTRL2_IDX   = 8'h17;
   localparam logic [7:0] CTRL3_IDX   = 8'h18;
   localparam logic [7:0] CTRL1_ADDR  = CTRL1_IDX << 2;
   localparam logic [7:0] CTRL2_ADDR  = CTRL2_IDX << 2;
   localparam logic [7:0] CTRL3_ADDR  = CTRL3_IDX << 2;
   localparam logic [7:0] STATUS_ADDR = 8'h80;
   localparam logic [7:0] MASK_ADDR   = 8'h84;
   localparam logic [7:0] STATE_ADDR  = 8'h88;

   localparam logic [7:0] CTRL1_RST   = 8'h96;
   localparam logic [7:0] CTRL2_RST   = 8'h2d;
   localparam logic [7:0] CTRL3_RST   = 8'h19;
   localparam logic [7:0] CTRL3_WMASK = 8'hbf;

   // field positions
   localparam int DLY_LO_MSB = 7;
   localparam int DLY_LO_LSB = 6;
   localparam int DLY_HI_BIT = 7;
   localparam int MAX_MSB    = 5;
   localparam int TOUT_MSB   = 6;
   localparam int TOUT_LSB   = 3;
   localparam int CONF_MSB   = 2;
   localparam int EN_BIT     = 7;
   localparam int RAS_MSB    = 5;

   // status bits
   localparam int ST_VALID = 0;
   localparam int ST_END   = 1;
   localparam int ST_HIGH  = 2;
   localparam int ST_LOW   = 3;
   localparam int ST_W     = 4;

   typedef enum logic [3:0] {
      RVT_IDLE  = 4'b0001,
      RVT_QUAL  = 4'b0010,
      RVT_DELAY = 4'b0100,
      RVT_VALID = 4'b1000
   } rvt_state_t;

endpackage : rvt_pkg

`default_nettype wire

// ==== hdl/rvt_tick_if.sv ====
// tick request and tick pulse between the timer core and its divider
`default_nettype none

interface rvt_tick_if;
   logic run;
   logic tick;
   modport gen (input run, output tick);
   modport use_ (output run, input tick);
endinterface : rvt_tick_if

`default_nettype wire

// ==== hdl/rvt_tick_gen.sv ====
// divider that makes the one-cycle periodic tick
`default_nettype none

module rvt_tick_gen #(
   parameter int unsigned CYCLES = rvt_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // tick
   rvt_tick_if.gen  tk
);
   import rvt_pkg::*;

   localparam int unsigned CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          tick_q;
   logic          tick_d;

   assign tk.tick = tick_q;

   // phase restarts whenever the core stops, so the first tick
   // after enabling is a full period away
   always_comb begin
      cnt_d  = '0;
      tick_d = 1'b0;
      if (tk.run) begin
         if (cnt_q == CW'(CYCLES - 1)) begin
            tick_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

endmodule : rvt_tick_gen

`default_nettype wire

// ==== dv/rvt_ring_source.sv ====
// line-side ring detector model: periodic one-cycle crossing events
`default_nettype none

module rvt_ring_source (
   // clock
   input  wire logic        sys_clk,
   // control from the bench
   input  wire logic        run,
   input  wire logic [31:0] gapCycles,
   // line side
   output var  logic        ringEvent
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] cnt;

   // a long gap stands for a slow ringer, a short one for a fast one
   always @(posedge sys_clk) begin
      if (!run) begin
         ringEvent <= 1'b0;
         cnt <= '0;
      end else if (cnt == 0) begin
         ringEvent <= 1'b1;
         cnt <= gapCycles - 1;
      end else begin
         ringEvent <= 1'b0;
         cnt <= cnt - 1;
      end
   end
endmodule : rvt_ring_source

`default_nettype wire

// ==== dv/ring_validation_timer_tb.sv ====
// self-checking bench for the ring validation timer
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
$display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module ring_validation_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rvt_pkg::*;
   // --------------------
   // signals
   // --------------------
   localparam int TK = 10;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] hwdata = '0;
   logic        hreadyout, hresp, ringEvent, ringValid, irq;
   logic [31:0] hrdata, rd;
   logic        run = 1'b0;
   logic [31:0] gapCycles = 32'd100;
   int          failures = 0;
   int          num_checks = 0;
   int          seed = 32'hb459be8a;
   int          dl [8] = '{0, 1, 2, 4, 7, 0, 3, 5};
   logic [7:0]  shadow [logic [7:0]];

   always #10 sys_clk = ~sys_clk;

   rvt_ring_validate #(.TICK_CYCLES(TK)) rvt_ring_validate_i (
      .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .ringEvent(ringEvent), .ringValid(ringValid),
      .irq(irq));

   rvt_ring_source rvt_ring_source_i (
      .sys_clk(sys_clk), .run(run), .gapCycles(gapCycles),
      .ringEvent(ringEvent));

   // --------------------
   // tasks
   // --------------------
   task automatic close_out();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1 && ++n < 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      // read data taken as it stands just before the closing edge
      do begin
         @(negedge sys_clk);
         r = hrdata;
         @(posedge sys_clk);
      end while (hreadyout !== 1'b1 && ++n < 50);
      if (n >= 50) begin
         failures++;
      end
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d}, rd);
      if (shadow.exists(a)) begin
         shadow[a] = d & ((a == CTRL3_ADDR) ? 8'hbf :
                          (a == MASK_ADDR) ? 8'h0f : 8'hff);
      end
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, rd);
      `CHK(rd, e)
   endtask : rdc

   task automatic wt(input int n);
      repeat (n * TK) @(posedge sys_clk);
   endtask : wt

   task automatic wait_ev();
      int n;
      n = 0;
      do @(posedge sys_clk); while (ringEvent !== 1'b1 && ++n < 9000);
   endtask : wait_ev

   // in-band ring: valid after confirm plus delay, off after timeout
   task automatic ring(input int dly, input int ring_confirm_time_sel, input int ring_end_timeout_sel);
      int t;
      t = CONFIRM_MS[ring_confirm_time_sel] / 2 + dly * 128;
      wr(CTRL1_ADDR, {dly[1:0], 6'h16});
      wr(CTRL2_ADDR, {dly[2], ring_end_timeout_sel[3:0], ring_confirm_time_sel[2:0]});
      gapCycles <= (5 + ($unsigned($random(seed)) % 16)) * TK;
      run <= 1'b1;
      wait_ev();
      wt(t - 3);
      `CHK(ringValid, 1'b0)
      wt(6);
      `CHK(ringValid, 1'b1)
      wait_ev();
      run <= 1'b0;
      wt(ring_end_timeout_sel * 64 - 4);
      `CHK(ringValid, 1'b1)
      wt(8);
      `CHK(ringValid, 1'b0)
      rdc(STATUS_ADDR, 32'h3);
      `CHK(irq, |shadow[MASK_ADDR][1:0])
      $display("ring delay %0d confirm %0d done", dly, ring_confirm_time_sel);
   endtask : ring

   // a gap of g ticks; v and st are the expected ring flag and status
   task automatic gap_run(input int g, input logic v, input logic [31:0] st);
      gapCycles <= g * TK;
      run <= 1'b1;
      wt(80);
      `CHK(ringValid, v)
      run <= 1'b0;
      wt(140);
      rdc(STATUS_ADDR, st);
      wr(STATUS_ADDR, 8'h0f);
      $display("gap %0d ticks done", g);
   endtask : gap_run

   // --------------------
   // main sequence
   // --------------------
   initial begin
      shadow[CTRL1_ADDR] = 8'h96;
      shadow[CTRL2_ADDR] = 8'h2d;
      shadow[CTRL3_ADDR] = 8'h19;
      shadow[MASK_ADDR] = 8'h00;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (shadow[a]) rdc(a, {24'h0, shadow[a]});
      rdc(STATUS_ADDR, 32'h0);
      rdc(STATE_ADDR, 32'h2);
      foreach (shadow[a]) begin
         wr(a, 8'($random(seed)) & 8'h7f);
         rdc(a, {24'h0, shadow[a]});
      end
      wr(8'ha0, 8'($random(seed)));
      rdc(8'ha0, 32'h0);
      $display("register test done");
      wr(CTRL1_ADDR, 8'h16);
      wr(CTRL2_ADDR, 8'h08);
      wr(CTRL3_ADDR, 8'h19);
      wr(MASK_ADDR, 8'h00);
      gap_run(10, 1'b0, 32'h0);
      rdc(STATE_ADDR, 32'h2);
      wr(CTRL3_ADDR, 8'h99);
      gap_run(2, 1'b0, 32'h6);
      gap_run(3, 1'b1, 32'h3);
      gap_run(24, 1'b1, 32'h3);
      gap_run(30, 1'b0, 32'ha);
      for (int i = 0; i < 8; i++) begin
         ring(dl[i], i, 1 + (i & 1));
         if (i == 0) begin
            wr(MASK_ADDR, 8'h01);
            wt(1);
            `CHK(irq, 1'b1)
            wr(STATUS_ADDR, 8'h01);
            wt(1);
            `CHK(irq, 1'b0)
            wr(MASK_ADDR, 8'h0f);
         end
         wr(STATUS_ADDR, 8'h0f);
      end
      close_out();
   end

   initial begin
      repeat (100000) @(posedge sys_clk);
      failures++;
      close_out();
   end
endmodule : ring_validation_timer_tb

`default_nettype wire
